// file: src/uct_command_routing.sv
// serial command issue register and reply routing
// assumes a single-cycle register port and a same-clock reply word stream
//
// Contract
// - bits 12 to 8 of the command issue register are a read-write packet byte count.
// - bits 7 to 6 are a read-write command kind that marks aborts and picks reply storage.
// - a normal command's reply goes to the serial reply store at 0A0h to 0B3h.
// - a transaction abort's 4-byte reply goes to 010h to 013h, leaving the reply store alone.
// - a memory stop or I/O abort's 8-byte reply goes to 018h to 01Fh.
// - a dormant or full-reset control command's reply goes to 0A0h to 0B3h.
// - after saving that reply the block drives the serial lanes into dormant state.
// - an abort issued while a block-gap halt holds the transfer keeps the data path stopped.
`timescale 1ns/1ps
module uct_command_routing
  import uct_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_resp_valid,
  input wire logic [DATA_W-1:0] i_resp_data,
  input wire logic i_resp_last,
  output logic o_cmd_issue,
  output logic [4:0] o_cmd_len,
  output logic [1:0] o_cmd_kind,
  output logic o_lane_dormant,
  output logic o_data_stop,
  output logic o_tran_flush,
  output logic o_full_reset
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [4:0] len;
    logic [1:0] kind;
    uct_phase_type phase;
    uct_cmd_kind_type act;
    logic [2:0] cnt;
    logic dormant;
    logic halt;
    logic abort_hold;
    logic stop;
    logic len_err;
    logic issue;
    logic flush;
    logic freset;
  } uct_state_type;

  localparam uct_state_type ST_RESET = '{
    len: LEN_RESET, kind: CT_NORMAL, phase: PH_IDLE, act: CT_NORMAL,
    cnt: 3'h0, default: 1'b0
  };

  uct_state_type st_ff;
  uct_state_type nxt_st_ff;
  uct_mem_if mif ();

  function automatic logic [MEM_AW-1:0] slot_base(input uct_cmd_kind_type k);
    case (k)
      CT_TRANS_ABORT: slot_base = IDX_TRANS_BASE;
      CT_STOP_ABORT: slot_base = IDX_STOP_BASE;
      default: slot_base = IDX_REPLY_BASE;
    endcase
  endfunction : slot_base

  function automatic logic [2:0] slot_words(input uct_cmd_kind_type k);
    case (k)
      CT_TRANS_ABORT: slot_words = WORDS_TRANS;
      CT_STOP_ABORT: slot_words = WORDS_STOP;
      default: slot_words = WORDS_REPLY;
    endcase
  endfunction : slot_words

  // {hit, index} for a readable storage word
  function automatic logic [MEM_AW:0] map_store(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - OFF_REPLY_LO;
    map_store = '0;
    if (a[1:0] == 2'b00 && a >= OFF_LEGACY_LO && a <= OFF_LEGACY_HI)
    begin
      map_store = {1'b1, 2'b00, a[3:2]};
    end
    else if (a[1:0] == 2'b00 && a >= OFF_REPLY_LO && a <= OFF_REPLY_HI)
    begin
      map_store = {1'b1, IDX_REPLY_BASE + MEM_AW'(off[ADDR_W-1:2])};
    end
  endfunction : map_store

  function automatic logic is_abort(input logic [1:0] k);
    is_abort = (k == CT_TRANS_ABORT) || (k == CT_STOP_ABORT);
  endfunction : is_abort

  ////////////////////////////////////////////////////////////////////////////////
  logic [4:0] w_len;
  logic [1:0] w_kind;
  logic w_len_ok;
  logic [MEM_AW:0] rd_map;

  assign w_len = i_wdata[LEN_MSB:LEN_LSB];
  assign w_kind = i_wdata[KIND_MSB:KIND_LSB];
  assign w_len_ok = (w_len >= LEN_MIN) && (w_len <= LEN_MAX);
  assign rd_map = map_store(i_addr);

  always_comb
  begin
    nxt_st_ff = st_ff;
    nxt_st_ff.issue = 1'b0;
    nxt_st_ff.flush = 1'b0;
    nxt_st_ff.freset = 1'b0;
    mif.wr_en = 1'b0;
    mif.wr_addr = slot_base(st_ff.act) + MEM_AW'(st_ff.cnt);
    mif.wr_data = i_resp_data;
    // reply capture into the slot of the latched kind
    case (st_ff.phase)
      PH_IDLE:
      begin
        nxt_st_ff.cnt = st_ff.cnt;
      end
      PH_WAIT:
      begin
        if (i_resp_valid)
        begin
          if (st_ff.cnt < slot_words(st_ff.act))
          begin
            mif.wr_en = 1'b1;
            nxt_st_ff.cnt = st_ff.cnt + 3'h1;
          end
          if (i_resp_last)
          begin
            nxt_st_ff.phase = PH_IDLE;
            if (st_ff.act == CT_DORMANT)
            begin
              nxt_st_ff.dormant = 1'b1;
            end
          end
        end
      end
      default:
      begin
        nxt_st_ff.phase = PH_IDLE;
      end
    endcase
    // register writes
    if (i_wr && i_addr == OFF_CMD_ISSUE)
    begin
      nxt_st_ff.len = w_len;
      nxt_st_ff.kind = w_kind;
      if (st_ff.phase == PH_IDLE)
      begin
        nxt_st_ff.len_err = !w_len_ok;
        if (w_len_ok)
        begin
          nxt_st_ff.issue = 1'b1;
          nxt_st_ff.act = uct_cmd_kind_type'(w_kind);
          nxt_st_ff.cnt = 3'h0;
          nxt_st_ff.phase = PH_WAIT;
          nxt_st_ff.dormant = 1'b0;
          if (is_abort(w_kind) && st_ff.halt)
          begin
            nxt_st_ff.abort_hold = 1'b1;
          end
        end
      end
    end
    if (i_wr && i_addr == OFF_CTRL)
    begin
      nxt_st_ff.halt = i_wdata[CTRL_HALT_BIT];
      if (i_wdata[CTRL_FLUSH_BIT])
      begin
        nxt_st_ff.flush = 1'b1;
        nxt_st_ff.abort_hold = 1'b0;
      end
      if (i_wdata[CTRL_FRESET_BIT])
      begin
        nxt_st_ff = ST_RESET;
        nxt_st_ff.freset = 1'b1;
        nxt_st_ff.flush = i_wdata[CTRL_FLUSH_BIT];
      end
    end
    nxt_st_ff.stop = nxt_st_ff.halt | nxt_st_ff.abort_hold;
    // read port, answered by the storage flop
    mif.rd_en = i_rd;
    mif.rd_from_mem = rd_map[MEM_AW];
    mif.rd_addr = rd_map[MEM_AW-1:0];
    if (i_addr == OFF_CMD_ISSUE)
    begin
      mif.rd_alt = {19'h0_0000, st_ff.len, st_ff.kind, 6'h00};
    end
    else if (i_addr == OFF_CTRL)
    begin
      mif.rd_alt = {31'h0000_0000, st_ff.halt};
    end
    else if (i_addr == OFF_STATUS)
    begin
      mif.rd_alt = {28'h000_0000, st_ff.len_err, st_ff.stop, st_ff.dormant,
                    st_ff.phase == PH_WAIT};
    end
    else
    begin
      mif.rd_alt = RDATA_RESET;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_ff <= ST_RESET;
    end
    else
    begin
      st_ff <= nxt_st_ff;
    end
  end

  uct_reply_mem u_store (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .mif(mif.mem)
  );

  assign o_rdata = mif.rd_data;
  assign o_cmd_issue = st_ff.issue;
  assign o_cmd_len = st_ff.len;
  assign o_cmd_kind = st_ff.act;
  assign o_lane_dormant = st_ff.dormant;
  assign o_data_stop = st_ff.stop;
  assign o_tran_flush = st_ff.flush;
  assign o_full_reset = st_ff.freset;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic ctrl_wr_quiet;
  assign ctrl_wr_quiet = !(i_wr && i_addr == OFF_CTRL);

  len_field_store_a: assert property (
    i_wr && i_addr == OFF_CMD_ISSUE && ctrl_wr_quiet |=> st_ff.len == $past(w_len))
    else $error("packet byte count not stored");

  kind_field_store_a: assert property (
    i_wr && i_addr == OFF_CMD_ISSUE ##1 i_rd && i_addr == OFF_CMD_ISSUE
    |=> o_rdata[KIND_MSB:KIND_LSB] == $past(st_ff.kind))
    else $error("command kind readback wrong");

  issue_len_legal_a: assert property (
    o_cmd_issue |-> o_cmd_len >= LEN_MIN && o_cmd_len <= LEN_MAX && st_ff.phase == PH_WAIT)
    else $error("command issued with unused byte count");

  normal_reply_slot_a: assert property (
    mif.wr_en && st_ff.act == CT_NORMAL |-> mif.wr_addr >= IDX_REPLY_BASE)
    else $error("normal reply outside reply store");

  trans_reply_slot_a: assert property (
    mif.wr_en && st_ff.act == CT_TRANS_ABORT |-> mif.wr_addr == IDX_TRANS_BASE)
    else $error("transaction abort reply misplaced");

  stop_reply_slot_a: assert property (
    mif.wr_en && st_ff.act == CT_STOP_ABORT
    |-> mif.wr_addr == IDX_STOP_BASE || mif.wr_addr == IDX_STOP_BASE + 4'h1)
    else $error("stop abort reply misplaced");

  dormant_reply_slot_a: assert property (
    mif.wr_en && st_ff.act == CT_DORMANT |-> mif.wr_addr >= IDX_REPLY_BASE)
    else $error("dormant reply outside reply store");

  lane_dormant_a: assert property (
    st_ff.phase == PH_WAIT && i_resp_valid && i_resp_last && st_ff.act == CT_DORMANT
    && ctrl_wr_quiet |=> o_lane_dormant && st_ff.phase == PH_IDLE)
    else $error("lanes not sent dormant");

  full_reset_pulse_a: assert property (
    i_wr && i_addr == OFF_CTRL && i_wdata[CTRL_FRESET_BIT]
    |=> o_full_reset && !o_cmd_issue
    ##1 o_full_reset == $past(i_wr && i_addr == OFF_CTRL && i_wdata[CTRL_FRESET_BIT]))
    else $error("full reset pulse wrong");

  flush_pulse_a: assert property (
    i_wr && i_addr == OFF_CTRL && i_wdata[CTRL_FLUSH_BIT]
    |=> o_tran_flush
    ##1 o_tran_flush == $past(i_wr && i_addr == OFF_CTRL && i_wdata[CTRL_FLUSH_BIT]))
    else $error("flush pulse wrong");

  abort_halt_hold_a: assert property (
    o_cmd_issue && is_abort(o_cmd_kind) && $past(st_ff.halt)
    |-> o_data_stop && st_ff.abort_hold)
    else $error("abort under halt did not hold the data path");

  abort_hold_keep_a: assert property (
    st_ff.abort_hold
    && !(i_wr && i_addr == OFF_CTRL && (i_wdata[CTRL_FLUSH_BIT] || i_wdata[CTRL_FRESET_BIT]))
    |=> o_data_stop && st_ff.abort_hold)
    else $error("data path resumed after abort under halt");

  latched_kind_a: assert property (
    st_ff.phase == PH_WAIT && !o_cmd_issue |-> $stable(o_cmd_kind))
    else $error("reply target changed while outstanding");

  normal_reply_c: cover property (o_cmd_issue && o_cmd_kind == CT_NORMAL ##[1:20] mif.wr_en);
  trans_abort_c: cover property (mif.wr_en && st_ff.act == CT_TRANS_ABORT);
  dormant_c: cover property ($rose(o_lane_dormant));
  abort_under_halt_c: cover property ($rose(st_ff.abort_hold));

endmodule : uct_command_routing

// file: src/uct_pkg.sv
// constants and types for the serial command issue and reply routing block
// assumes one 200 MHz clock; byte addresses on an 8-bit register port
package uct_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MEM_AW = 4;

  // register byte offsets
  localparam logic [7:0] OFF_CMD_ISSUE = 8'h00c0;
  localparam logic [7:0] OFF_CTRL = 8'h00c4;
  localparam logic [7:0] OFF_STATUS = 8'h00c8;
  localparam logic [7:0] OFF_LEGACY_LO = 8'h0010;
  localparam logic [7:0] OFF_LEGACY_HI = 8'h001c;
  localparam logic [7:0] OFF_REPLY_LO = 8'h00a0;
  localparam logic [7:0] OFF_REPLY_HI = 8'h00b0;

  // field positions
  localparam int LEN_LSB = 8;
  localparam int LEN_MSB = 12;
  localparam int KIND_LSB = 6;
  localparam int KIND_MSB = 7;
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam int CTRL_FRESET_BIT = 2;

  // legal packet byte counts
  localparam logic [4:0] LEN_MIN = 5'h04;
  localparam logic [4:0] LEN_MAX = 5'h14;

  // reset values
  localparam logic [4:0] LEN_RESET = 5'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // storage slots: legacy words 0..3, serial reply store words 8..12
  localparam logic [MEM_AW-1:0] IDX_TRANS_BASE = 4'h0;
  localparam logic [MEM_AW-1:0] IDX_STOP_BASE = 4'h2;
  localparam logic [MEM_AW-1:0] IDX_REPLY_BASE = 4'h8;
  localparam logic [2:0] WORDS_REPLY = 3'h5;
  localparam logic [2:0] WORDS_TRANS = 3'h1;
  localparam logic [2:0] WORDS_STOP = 3'h2;

  typedef enum logic [1:0] {
    CT_NORMAL = 2'b00,
    CT_TRANS_ABORT = 2'b01,
    CT_STOP_ABORT = 2'b10,
    CT_DORMANT = 2'b11
  } uct_cmd_kind_type;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_WAIT = 1'b1
  } uct_phase_type;

endpackage : uct_pkg

// file: src/uct_mem_if.sv
// carrier between the routing logic and its reply storage
// assumes both ends on the same clock
`timescale 1ns/1ps
interface uct_mem_if;
  import uct_pkg::*;
  logic wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic rd_en;
  logic rd_from_mem;
  logic [MEM_AW-1:0] rd_addr;
  logic [DATA_W-1:0] rd_alt;
  logic [DATA_W-1:0] rd_data;
  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_en, rd_from_mem, rd_addr, rd_alt,
    input rd_data
  );
  modport mem (
    input wr_en, wr_addr, wr_data, rd_en, rd_from_mem, rd_addr, rd_alt,
    output rd_data
  );
endinterface : uct_mem_if

// file: src/uct_reply_mem.sv
// reply storage: 16 words, one write port, registered read port
// assumes the read port also carries non-memory register data to register
`timescale 1ns/1ps
module uct_reply_mem
  import uct_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  uct_mem_if.mem mif
);

  logic [DATA_W-1:0] store [0:(1<<MEM_AW)-1];
  logic [DATA_W-1:0] rd_data_ff;

  always_ff @(posedge i_clk)
  begin
    if (mif.wr_en)
    begin
      store[mif.wr_addr] <= mif.wr_data;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_data_ff <= RDATA_RESET;
    end
    else if (mif.rd_en)
    begin
      rd_data_ff <= mif.rd_from_mem ? store[mif.rd_addr] : mif.rd_alt;
    end
    else
    begin
      rd_data_ff <= RDATA_RESET;
    end
  end

  assign mif.rd_data = rd_data_ff;

endmodule : uct_reply_mem

// file: dv/uct_card_model.sv
// card side of the reply stream: answers each issued command with its reply words
// assumes the same clock as the routing block; i_slow delays the answer by 3 cycles
`timescale 1ns/1ps
module uct_card_model
  import uct_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [1:0] i_kind,
  input wire logic i_slow,
  output logic o_valid,
  output logic [DATA_W-1:0] o_data,
  output logic o_last
);
  logic [3:0] left_ff;
  logic [3:0] wait_ff;
  logic [3:0] idx_ff;
  logic [1:0] kind_ff;
  logic [DATA_W-1:0] word;
  ////////////////////////////////////////////////////////////
  assign word = {8'h5a, 14'h0000, kind_ff, 4'h0, idx_ff};
  assign o_valid = (left_ff != 4'h0) && (wait_ff == 4'h0);
  assign o_last = o_valid && (left_ff == 4'h1);
  // released line shows the inverse, never a stale word
  assign o_data = o_valid ? word : ~word;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      left_ff <= 4'h0;
      wait_ff <= 4'h0;
      idx_ff <= 4'h0;
      kind_ff <= 2'h0;
    end
    else if (i_start)
    begin
      // reply sizes 4, 8 and 20 bytes per kind
      left_ff <= (i_kind == 2'b01) ? 4'h1 : (i_kind == 2'b10) ? 4'h2 : 4'h5;
      wait_ff <= i_slow ? 4'h3 : 4'h0;
      idx_ff <= 4'h0;
      kind_ff <= i_kind;
    end
    else if (wait_ff != 4'h0)
      wait_ff <= wait_ff - 4'h1;
    else if (left_ff != 4'h0)
    begin
      left_ff <= left_ff - 4'h1;
      idx_ff <= idx_ff + 4'h1;
    end
  end
endmodule : uct_card_model

// file: dv/tb.sv
// self-checking bench for the command routing block with the card reply model
// assumes one 200 MHz clock and the single-cycle register port
`timescale 1ns/1ps
module tb;
  import uct_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] len;
    logic [7:0] base;
    logic [2:0] nw;
  } uct_row_type;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic slow = 1'b0;
  logic [31:0] o_rdata;
  logic c_valid;
  logic [31:0] c_data;
  logic c_last;
  logic o_cmd_issue;
  logic [4:0] o_cmd_len;
  logic [1:0] o_cmd_kind;
  logic o_lane_dormant;
  logic o_data_stop;
  logic o_tran_flush;
  logic o_full_reset;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  uct_row_type rows [4] = '{
    '{2'b00, 5'h04, 8'ha0, 3'h5}, '{2'b01, 5'h14, 8'h10, 3'h1},
    '{2'b10, 5'h08, 8'h18, 3'h2}, '{2'b11, 5'h0c, 8'ha0, 3'h5}};
  ////////////////////////////////////////////////////////////
  always #2.5 i_clk = ~i_clk;
  uct_command_routing dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_resp_valid(c_valid), .i_resp_data(c_data), .i_resp_last(c_last),
    .o_cmd_issue(o_cmd_issue), .o_cmd_len(o_cmd_len), .o_cmd_kind(o_cmd_kind),
    .o_lane_dormant(o_lane_dormant), .o_data_stop(o_data_stop),
    .o_tran_flush(o_tran_flush), .o_full_reset(o_full_reset));
  uct_card_model card_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(o_cmd_issue),
    .i_kind(o_cmd_kind), .i_slow(slow), .o_valid(c_valid), .o_data(c_data),
    .o_last(c_last));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rep_word(input logic [1:0] k, input int n);
    rep_word = {8'h5a, 14'h0000, k, 4'h0, n[3:0]};
  endfunction : rep_word
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", exp, o_rdata);
  endtask : rd
  task automatic wait_done();
    int k;
    k = 0;
    while (!(c_valid === 1'b1 && c_last === 1'b1) && k < 40)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk("reply_end", 32'h1, {31'h0, k < 40});
    @(posedge i_clk);
    #1;
  endtask : wait_done
  task automatic issue(input logic [4:0] len, input logic [1:0] kind);
    wr(OFF_CMD_ISSUE, {19'h0, len, kind, 6'h00});
    #1;
    chk("cmd_issue", 32'h1, {31'h0, o_cmd_issue});
    chk("cmd_len", {27'h0, len}, {27'h0, o_cmd_len});
    chk("cmd_kind", {30'h0, kind}, {30'h0, o_cmd_kind});
    wait_done();
  endtask : issue
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("reset_outs", 32'h0, {o_cmd_issue, o_lane_dormant, o_data_stop, o_full_reset});
    rd(OFF_CMD_ISSUE, 32'h0000_0000);
    for (int r = 0; r < 4; r++)
    begin
      issue(rows[r].len, rows[r].kind);
      for (int n = 0; n < rows[r].nw; n++)
        rd(rows[r].base + 8'(4 * n), rep_word(rows[r].kind, n));
      if (rows[r].kind == 2'b01)
      begin
        rd(OFF_REPLY_LO, rep_word(2'b00, 0));
        wr(OFF_CTRL, 32'h0000_0004);
        #1;
        chk("full_reset", 32'h1, {31'h0, o_full_reset});
      end
      if (rows[r].kind == 2'b10)
      begin
        wr(OFF_CTRL, 32'h0000_0002);
        #1;
        chk("tran_flush", 32'h1, {31'h0, o_tran_flush});
      end
      if (rows[r].kind == 2'b11)
      begin
        chk("lane_dormant", 32'h1, {31'h0, o_lane_dormant});
        rd(OFF_STATUS, 32'h0000_0002);
      end
    end
    // unused byte counts just below and above the legal range
    foreach (rows[i])
    begin
      if (i < 2)
      begin
        wr(OFF_CMD_ISSUE, {19'h0, (i == 0) ? 5'h03 : 5'h15, 8'h00});
        #1;
        chk("bad_len_issue", 32'h0, {31'h0, o_cmd_issue});
        rd(OFF_STATUS, 32'h0000_000a);
      end
    end
    rd(OFF_CMD_ISSUE, 32'h0000_1500);
    // kind rewritten while a slow reply is outstanding
    slow <= 1'b1;
    wr(OFF_CMD_ISSUE, 32'h0000_0800);
    wr(OFF_CMD_ISSUE, 32'h0000_0440);
    rd(OFF_CMD_ISSUE, 32'h0000_0440);
    wait_done();
    rd(OFF_REPLY_LO, rep_word(2'b00, 0));
    chk("kind_latched", 32'h0, {30'h0, o_cmd_kind});
    rd(OFF_CMD_ISSUE, 32'h0000_0440);
    slow <= 1'b0;
    // abort under a block-gap halt keeps the data path stopped
    wr(OFF_CTRL, 32'h0000_0001);
    issue(5'h04, 2'b01);
    wr(OFF_CTRL, 32'h0000_0000);
    @(posedge i_clk);
    #1;
    chk("data_stop_hold", 32'h1, {31'h0, o_data_stop});
    wr(OFF_CTRL, 32'h0000_0002);
    @(posedge i_clk);
    #1;
    chk("data_stop_free", 32'h0, {31'h0, o_data_stop});
    rd(8'h40, 32'h0000_0000);
    report_and_stop();
  end
endmodule : tb
